// file: include/pwm_pkg.sv
// constants and types for the pulse-width generator unit
// assumes a single 10 MHz clock domain and no register bus
//
// Functional notes
// - down mode: count load to zero, reload, keep counting down
// - up/down mode: count zero up to load, back down, repeat
// - direction low in down mode; in up/down, high while counting up
// - one-cycle zero pulse at value zero, load pulse at load value
// - down mode: load pulse follows zero pulse in the next cycle
// - each comparator pulses one cycle when its value equals counter
// - up/down matches split by direction into up and down events
// - a match value above load never produces a match pulse
// - four events in down mode, six in up/down mode
// - match events coinciding with zero or load are ignored by the signal actions
// - coincident matches: first signal uses A only, second B only
// - per event per signal action: none, toggle, low or high
// - dead-band off: both generated signals pass unchanged
// - dead-band on: first output is first signal, rise delayed
// - dead-band on: second output is inverse, rise delayed after fall
// - interrupt when any event in selected subset occurs
// - converter trigger when any event in second subset occurs
// - interrupt and trigger use raw events, not dead-band edges
// - counter, load and compare values are 16 bits
package pwm_pkg;
    localparam int CNT_W   = 16;
    localparam int DB_W    = 12;
    localparam int EVT_N   = 6;
    // event vector bit positions
    localparam int EV_ZERO = 0;
    localparam int EV_LOAD = 1;
    localparam int EV_AUP  = 2;
    localparam int EV_ADN  = 3;
    localparam int EV_BUP  = 4;
    localparam int EV_BDN  = 5;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    // action codes
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TGL  = 2'h1;
    localparam logic [1:0] ACT_LOW  = 2'h2;
    localparam logic [1:0] ACT_HIGH = 2'h3;
    typedef logic [EVT_N-1:0] evt_t;
endpackage

// file: src/pwm_deadband.sv
// rising-edge delay stage used twice by the dead-band generator
// assumes the same clock and reset as the generator top
`timescale 1ns/100ps
`default_nettype none
module pwm_deadband
    import pwm_pkg::*;
#(
    parameter int W = pwm_pkg::DB_W
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         sig_i,
    input  wire logic [W-1:0] delay_i,
    output logic              sig_o
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         out_q;
    logic         out_d;

    // falling edges pass at once; rising edges wait delay_i cycles
    always_comb begin
        cnt_d = cnt_q;
        out_d = out_q;
        if (!sig_i) begin
            out_d = 1'b0;
            cnt_d = '0;
        end else if (!out_q) begin
            if (cnt_q >= delay_i) begin
                out_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    // register the delay state
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            out_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end

    assign sig_o = out_q;
endmodule
`default_nettype wire

// file: src/pwm_gen.sv
// single pulse-width generator: counter, comparators, actions,
// dead-band pair and interrupt / converter trigger selection
// assumes all control inputs are synchronous to SYS_CLK_I
`timescale 1ns/100ps
`default_nettype none
module pwm_gen
    import pwm_pkg::*;
(
    input  wire logic                       SYS_CLK_I,
    input  wire logic                       SYS_RST_I,
    input  wire logic                       ENABLE_I,
    input  wire logic                       UPDOWN_MODE_I,
    input  wire logic [pwm_pkg::CNT_W-1:0]  LOAD_I,
    input  wire logic [pwm_pkg::CNT_W-1:0]  CMP_A_I,
    input  wire logic [pwm_pkg::CNT_W-1:0]  CMP_B_I,
    input  wire logic [2*pwm_pkg::EVT_N-1:0] ACT_FIRST_I,
    input  wire logic [2*pwm_pkg::EVT_N-1:0] ACT_SECOND_I,
    input  wire logic                       DB_ENABLE_I,
    input  wire logic [pwm_pkg::DB_W-1:0]   DB_RISE_I,
    input  wire logic [pwm_pkg::DB_W-1:0]   DB_FALL_I,
    input  wire logic [pwm_pkg::EVT_N-1:0]  INT_SEL_I,
    input  wire logic [pwm_pkg::EVT_N-1:0]  TRIG_SEL_I,
    output logic [pwm_pkg::CNT_W-1:0]       COUNT_O,
    output logic                            DIR_O,
    output logic [pwm_pkg::EVT_N-1:0]       EVENTS_O,
    output logic                            PWM_OUT_FIRST_PIN_O,
    output logic                            PWM_OUT_SECOND_PIN_O,
    output logic                            INT_O,
    output logic                            ADC_TRIG_O
);
    import pwm_pkg::*;

    // apply one action code to a signal level
    function automatic logic apply_act(input logic [1:0] a,
                                       input logic       s);
        case (a)
            ACT_TGL:  apply_act = ~s;
            ACT_LOW:  apply_act = 1'b0;
            ACT_HIGH: apply_act = 1'b1;
            default:  apply_act = s;
        endcase
    endfunction

    // run all events through one action table, matches before zero/load
    function automatic logic gen_next(input logic [2*EVT_N-1:0] tbl,
                                      input evt_t ev, input logic s);
        logic r;
        r = s;
        for (int i = EVT_N - 1; i >= 0; i--) begin
            if (ev[i]) begin
                r = apply_act(tbl[2*i +: 2], r);
            end
        end
        gen_next = r;
    endfunction

    typedef enum logic {DIR_DOWN, DIR_UP} dir_t;

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    dir_t             dir_q;
    dir_t             dir_d;
    evt_t             ev;
    logic             match_a;
    logic             match_b;
    logic             gen_first_q;
    logic             gen_first_d;
    logic             gen_second_q;
    logic             gen_second_d;
    logic             db_first;
    logic             db_second;
    logic             out_first_q;
    logic             out_first_d;
    logic             out_second_q;
    logic             out_second_d;
    evt_t             ev_q;
    evt_t             ev_d;
    logic             int_q;
    logic             int_d;
    logic             trig_q;
    logic             trig_d;
    logic             dir_out_q;
    logic             dir_out_d;
    logic [CNT_W-1:0] cnt_out_q;

    // counter next value and direction
    always_comb begin
        cnt_d = cnt_q;
        dir_d = dir_q;
        if (!ENABLE_I) begin
            cnt_d = CNT_RST;
            dir_d = DIR_DOWN;
        end else if (!UPDOWN_MODE_I) begin
            dir_d = DIR_DOWN;
            if (cnt_q == CNT_RST || cnt_q > LOAD_I) begin
                cnt_d = LOAD_I;
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
        end else if (dir_q == DIR_UP) begin
            if (cnt_q >= LOAD_I) begin
                dir_d = DIR_DOWN;
                cnt_d = (LOAD_I == CNT_RST) ? CNT_RST
                                            : LOAD_I - 1'b1;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end else begin
            if (cnt_q == CNT_RST) begin
                dir_d = DIR_UP;
                cnt_d = (LOAD_I == CNT_RST) ? CNT_RST
                                            : 16'h0001;
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
        end
    end

    // register the counter
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            cnt_q <= CNT_RST;
            dir_q <= DIR_DOWN;
        end else begin
            cnt_q <= cnt_d;
            dir_q <= dir_d;
        end
    end

    // raw events from the current count
    assign match_a = ENABLE_I && (CMP_A_I <= LOAD_I)
                     && (cnt_q == CMP_A_I);
    assign match_b = ENABLE_I && (CMP_B_I <= LOAD_I)
                     && (cnt_q == CMP_B_I);
    always_comb begin
        ev          = '0;
        ev[EV_ZERO] = ENABLE_I && (cnt_q == CNT_RST);
        ev[EV_LOAD] = ENABLE_I && (cnt_q == LOAD_I);
        // down mode keeps direction low, so only the down events fire
        ev[EV_AUP]  = match_a && (dir_q == DIR_UP);
        ev[EV_ADN]  = match_a && (dir_q == DIR_DOWN);
        ev[EV_BUP]  = match_b && (dir_q == DIR_UP);
        ev[EV_BDN]  = match_b && (dir_q == DIR_DOWN);
    end

    // signal generation; matches dropped under zero or load
    always_comb begin
        evt_t ga;
        evt_t gb;
        ga = ev;
        gb = ev;
        if (ev[EV_ZERO] || ev[EV_LOAD]) begin
            ga[EV_AUP] = 1'b0;
            ga[EV_ADN] = 1'b0;
        end
        // first signal sees only A matches, second only B matches
        ga[EV_BUP] = 1'b0;
        ga[EV_BDN] = 1'b0;
        gb[EV_AUP] = 1'b0;
        gb[EV_ADN] = 1'b0;
        if (ev[EV_ZERO] || ev[EV_LOAD]) begin
            gb[EV_BUP] = 1'b0;
            gb[EV_BDN] = 1'b0;
        end
        if (!ENABLE_I) begin
            gen_first_d  = 1'b0;
            gen_second_d = 1'b0;
        end else begin
            gen_first_d  = gen_next(ACT_FIRST_I, ga, gen_first_q);
            gen_second_d = gen_next(ACT_SECOND_I, gb, gen_second_q);
        end
    end

    // register the generated signals
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            gen_first_q  <= 1'b0;
            gen_second_q <= 1'b0;
        end else begin
            gen_first_q  <= gen_first_d;
            gen_second_q <= gen_second_d;
        end
    end

    // rising-edge delay of the first signal
    pwm_deadband #(.W(DB_W)) u_db_rise (
        .clk_i   (SYS_CLK_I),
        .rst_i   (SYS_RST_I),
        .sig_i   (gen_first_q),
        .delay_i (DB_RISE_I),
        .sig_o   (db_first)
    );

    // rising-edge delay of the inverted first signal
    pwm_deadband #(.W(DB_W)) u_db_fall (
        .clk_i   (SYS_CLK_I),
        .rst_i   (SYS_RST_I),
        .sig_i   (~gen_first_q),
        .delay_i (DB_FALL_I),
        .sig_o   (db_second)
    );

    // output pair select and event selectors
    always_comb begin
        if (DB_ENABLE_I) begin
            out_first_d  = db_first;
            out_second_d = db_second && ENABLE_I;
        end else begin
            out_first_d  = gen_first_q;
            out_second_d = gen_second_q;
        end
        ev_d      = ev;
        int_d     = |(ev & INT_SEL_I);
        trig_d    = |(ev & TRIG_SEL_I);
        dir_out_d = (dir_q == DIR_UP);
    end

    // register outputs
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            out_first_q  <= 1'b0;
            out_second_q <= 1'b0;
            ev_q         <= '0;
            int_q        <= 1'b0;
            trig_q       <= 1'b0;
            dir_out_q    <= 1'b0;
            cnt_out_q    <= CNT_RST;
        end else begin
            out_first_q  <= out_first_d;
            out_second_q <= out_second_d;
            ev_q         <= ev_d;
            int_q        <= int_d;
            trig_q       <= trig_d;
            dir_out_q    <= dir_out_d;
            cnt_out_q    <= cnt_q;
        end
    end

    assign COUNT_O              = cnt_out_q;
    assign DIR_O                = dir_out_q;
    assign EVENTS_O             = ev_q;
    assign PWM_OUT_FIRST_PIN_O  = out_first_q;
    assign PWM_OUT_SECOND_PIN_O = out_second_q;
    assign INT_O                = int_q;
    assign ADC_TRIG_O           = trig_q;
endmodule
`default_nettype wire

// file: verif/pwm_gen_chk.sv
// port checker for the pulse-width generator
// assumes mode, load, match values and masks change only while disabled
`timescale 1ns/100ps
`default_nettype none
module pwm_gen_chk
    import pwm_pkg::*;
(
    input wire logic                      SYS_CLK_I,
    input wire logic                      SYS_RST_I,
    input wire logic                      ENABLE_I,
    input wire logic                      UPDOWN_MODE_I,
    input wire logic [pwm_pkg::CNT_W-1:0] LOAD_I,
    input wire logic [pwm_pkg::CNT_W-1:0] CMP_A_I,
    input wire logic [pwm_pkg::CNT_W-1:0] CMP_B_I,
    input wire logic                      DB_ENABLE_I,
    input wire logic [pwm_pkg::EVT_N-1:0] INT_SEL_I,
    input wire logic [pwm_pkg::EVT_N-1:0] TRIG_SEL_I,
    input wire logic [pwm_pkg::CNT_W-1:0] COUNT_O,
    input wire logic                      DIR_O,
    input wire logic [pwm_pkg::EVT_N-1:0] EVENTS_O,
    input wire logic                      PWM_OUT_FIRST_PIN_O,
    input wire logic                      PWM_OUT_SECOND_PIN_O,
    input wire logic                      INT_O,
    input wire logic                      ADC_TRIG_O
);
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    logic [1:0] en_q;
    logic       run;
    // enable history covers the output pipeline lag
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) en_q <= 2'h0;
        else en_q <= {en_q[0], ENABLE_I};
    end
    assign run = ENABLE_I & en_q[0] & en_q[1];
    zero_pulse_a: assert property (
        EVENTS_O[EV_ZERO] |-> COUNT_O == 16'h0000)
        else $error("zero event off zero count");
    load_pulse_a: assert property (
        EVENTS_O[EV_LOAD] |-> COUNT_O == LOAD_I)
        else $error("load event off load count");
    down_reload_a: assert property (
        run && !UPDOWN_MODE_I && EVENTS_O[EV_ZERO]
        |=> EVENTS_O[EV_LOAD] || !ENABLE_I)
        else $error("no load event after zero");
    down_step_a: assert property (
        run && !UPDOWN_MODE_I && COUNT_O != 16'h0000
        |=> !ENABLE_I || COUNT_O == $past(COUNT_O) - 16'h0001)
        else $error("down count step wrong");
    tri_step_a: assert property (
        run && UPDOWN_MODE_I && COUNT_O != 16'h0000
        |=> !ENABLE_I || COUNT_O == $past(COUNT_O) + 16'h0001
        || COUNT_O == $past(COUNT_O) - 16'h0001)
        else $error("up/down count step wrong");
    down_dir_a: assert property (
        run && !UPDOWN_MODE_I
        |-> !DIR_O && !EVENTS_O[EV_AUP] && !EVENTS_O[EV_BUP])
        else $error("up activity in down mode");
    match_a_a: assert property (
        EVENTS_O[EV_AUP] || EVENTS_O[EV_ADN]
        |-> COUNT_O == CMP_A_I && DIR_O == EVENTS_O[EV_AUP])
        else $error("first match event wrong");
    match_b_a: assert property (
        EVENTS_O[EV_BUP] || EVENTS_O[EV_BDN]
        |-> COUNT_O == CMP_B_I && CMP_B_I <= LOAD_I)
        else $error("second match event wrong");
    idle_quiet_a: assert property (
        !ENABLE_I && !en_q[0] && !en_q[1]
        |-> EVENTS_O == 6'h00 && COUNT_O == 16'h0000)
        else $error("activity while disabled");
    int_mask_a: assert property (
        INT_O == |(EVENTS_O & INT_SEL_I))
        else $error("interrupt mismatch");
    trig_mask_a: assert property (
        ADC_TRIG_O == |(EVENTS_O & TRIG_SEL_I))
        else $error("trigger mismatch");
    dead_gap_a: assert property (
        run && DB_ENABLE_I
        |-> !(PWM_OUT_FIRST_PIN_O && PWM_OUT_SECOND_PIN_O))
        else $error("both pins high");
endmodule
bind pwm_gen pwm_gen_chk pwm_gen_chk_i (.*);
`default_nettype wire

// file: verif/pwm_far_model.sv
// far side: gate drivers and converter input, counting high cycles
// assumes pins and trigger are synchronous to the generator clock
`timescale 1ns/100ps
`default_nettype none
module pwm_far_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        hi_side_i,
    input  wire logic        lo_side_i,
    input  wire logic        trig_i,
    output logic [31:0]      hi_cnt_o,
    output logic [31:0]      lo_cnt_o,
    output logic [31:0]      trig_cnt_o
);
    // conduction time of each switch and converter starts
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hi_cnt_o   <= 32'h0;
            lo_cnt_o   <= 32'h0;
            trig_cnt_o <= 32'h0;
        end else begin
            hi_cnt_o   <= hi_cnt_o + 32'(hi_side_i);
            lo_cnt_o   <= lo_cnt_o + 32'(lo_side_i);
            trig_cnt_o <= trig_cnt_o + 32'(trig_i);
        end
    end
endmodule
`default_nettype wire

// file: verif/pwm_gen_tb.sv
// self-checking bench: duty, event and dead-band checks by counting
// assumes the far-side model counts pin high time and triggers
`timescale 1ns/100ps
`default_nettype none
module pwm_gen_tb;
    import pwm_pkg::*;
    logic                 clk, rst, en, ud, dbe, dir, p1, p2, irq, trig;
    logic [CNT_W-1:0]     load, ca, cb, cnt;
    logic [2*EVT_N-1:0]   af, as;
    logic [DB_W-1:0]      dr, df, d;
    logic [EVT_N-1:0]     isel, tsel, ev;
    logic [31:0]          h1, h2, ht, w1, w2, wt, wi, b1, b2, seed;
    int                   n_mismatch, checked;
    pwm_gen pwm_gen_i (.SYS_CLK_I(clk), .SYS_RST_I(rst), .ENABLE_I(en),
        .UPDOWN_MODE_I(ud), .LOAD_I(load), .CMP_A_I(ca), .CMP_B_I(cb),
        .ACT_FIRST_I(af), .ACT_SECOND_I(as), .DB_ENABLE_I(dbe),
        .DB_RISE_I(dr), .DB_FALL_I(df), .INT_SEL_I(isel),
        .TRIG_SEL_I(tsel), .COUNT_O(cnt), .DIR_O(dir), .EVENTS_O(ev),
        .PWM_OUT_FIRST_PIN_O(p1), .PWM_OUT_SECOND_PIN_O(p2),
        .INT_O(irq), .ADC_TRIG_O(trig));
    pwm_far_model pwm_far_model_i (.clk_i(clk), .rst_i(rst),
        .hi_side_i(p1), .lo_side_i(p2), .trig_i(trig), .hi_cnt_o(h1),
        .lo_cnt_o(h2), .trig_cnt_o(ht));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // high cycles per period in down mode, high on zero, low on match
    function automatic int hi_dn(int l, int c);
        return (c == 0 || c > l) ? l + 1 : l + 1 - c;
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        if (n_mismatch == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // stop the generator so the next setup starts from idle
    task automatic off();
        @(posedge clk);
        #1 en = 1'b0;
        repeat (5) @(posedge clk);
        #1;
    endtask
    // run, settle three periods, then count over four periods
    task automatic go(input int p);
        logic [31:0] a1, a2, at;
        en = 1'b1;
        repeat (3 * p) @(posedge clk);
        #1;
        a1 = h1; a2 = h2; at = ht; wi = 0;
        repeat (4 * p) begin
            @(posedge clk);
            #1;
            if (irq === 1'b1) wi++;
        end
        w1 = h1 - a1; w2 = h2 - a2; wt = ht - at;
    endtask
    initial begin
        rst = 1'b1; en = 0; ud = 0; dbe = 0; load = 0; ca = 0; cb = 0;
        af = 0; as = 0; dr = 0; df = 0; isel = 0; tsel = 0;
        n_mismatch = 0; checked = 0; seed = 32'd92203;
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        // down mode: random widths, match at zero, beyond load, coincident
        isel = 6'h01; tsel = 6'h08; af = 12'h083;
        for (int i = 0; i < 8; i++) begin
            off();
            load = 16'h0004 + 16'(rnd() % 32);
            ca = (i == 0) ? 16'h0 : 16'(1 + rnd() % (load - 1));
            cb = (i == 1) ? load + 1 : (i == 2) ? ca
                 : 16'(1 + rnd() % (load - 1));
            as = (i >= 5) ? 12'h001 : 12'h803;
            go(load + 1);
            cmp(w1, 4 * hi_dn(load, ca));
            cmp(w2, i >= 5 ? 2 * (load + 1)
                           : 4 * hi_dn(load, cb));
            cmp(wi, 4);
            cmp(wt, 4);
        end
        // up/down mode: centred pulses from up and down matches
        off();
        ud = 1; isel = 6'h04; tsel = 6'h02; af = 12'h0B0; as = 12'hB00;
        for (int i = 0; i < 3; i++) begin
            off();
            load = 16'h0004 + 16'(rnd() % 32);
            ca = 16'(1 + rnd() % (load - 1));
            cb = 16'(1 + rnd() % (load - 1));
            go(2 * load);
            cmp(w1, 8 * (load - ca));
            cmp(w2, 8 * (load - cb));
            cmp(wi, 4);
            cmp(wt, 4);
        end
        // dead-band pair: a longer delay shortens both conduction times
        off();
        ud = 0; load = 16'h0013; ca = 16'h0008; dbe = 1;
        // first signal high on zero, low on A down match
        af = 12'h083; as = 12'h555;
        d = 12'(1 + rnd() % 6);
        for (int k = 0; k < 2; k++) begin
            off();
            dr = k ? d : 12'h000;
            df = dr;
            go(20);
            if (k == 0) begin
                b1 = w1;
                b2 = w2;
            end
        end
        cmp(b1 - w1, 4 * d);
        cmp(b2 - w2, 4 * d);
        off();
        final_report();
    end
endmodule
`default_nettype wire
